/* pkg/fpl_regs.vh */
// Function
// - a press of the abort button raises an interrupt request toward the local processor.
// - the abort interrupt fires on the edge of the filtered button, so one press gives one request.
// - the reset button resets every on-board device and drives backplane reset when system controller.
// - backplane reset comes from the reset button, power-up reset, watchdog expiry or a control bit.
// - the failure lamp lights while a board fault is present.
// - the status lamp lights while the processor is halted.
// - the run lamp lights while any local bus master runs a local bus cycle.
// - the system controller lamp lights while the board is backplane system controller.
// - the network lamp lights while the network controller owns the local bus.
// - the disk lamp lights while the disk controller owns the local bus.
// - the backplane lamp lights while the board is master or slave of a backplane cycle.
// - power-up and every reset start initialization of processor, hardware and firmware.
`ifndef FPL_REGS_VH
`define FPL_REGS_VH

`define FPL_CLK_MHZ        250
`define FPL_DEBOUNCE_US    1000
`define FPL_DEBOUNCE_CYC   (`FPL_DEBOUNCE_US * `FPL_CLK_MHZ)
`define FPL_RST_HOLD_NS    1000
`define FPL_RST_HOLD_CYC   ((`FPL_RST_HOLD_NS * `FPL_CLK_MHZ) / 1000)
`define FPL_CNT_W          20

`endif

/* hw/fpl_debounce.v */
`timescale 1ns/1ps
`default_nettype none
// three-stage sync plus stability filter for a push button (active high = pressed)
module fpl_debounce #(
    parameter integer STABLE_CYC = 250000,
    parameter integer CNT_W      = 20
) (
    input  wire       clock_in,
    input  wire       rst_b_in,
    input  wire       button_in,
    output reg        level_out,
    output reg        rise_out
);
    reg [2:0]       sync_reg;
    reg [CNT_W-1:0] count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // stage 0 is only read by stage 1; stages 1 and 2 must agree before counting
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            sync_reg  <= 3'h0;
            count_reg <= {CNT_W{1'b0}};
            level_out <= 1'b0;
            rise_out  <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], button_in};
            rise_out <= 1'b0;
            if (sync_reg[2] != sync_reg[1] || sync_reg[2] == level_out) begin
                count_reg <= {CNT_W{1'b0}}; // bounce restarts the wait
            end else if (count_reg == STABLE_CYC[CNT_W-1:0] - 1'b1) begin
                count_reg <= {CNT_W{1'b0}};
                level_out <= sync_reg[2];
                rise_out  <= sync_reg[2]; // edge, not level: one pulse per press
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end
endmodule // fpl_debounce
`default_nettype wire

/* hw/fpl_front_panel.v */
`timescale 1ns/1ps
`default_nettype none
`include "fpl_regs.vh"
// front panel: abort interrupt, reset distribution, status lamps
module fpl_front_panel #(
    parameter integer DEBOUNCE_CYC = `FPL_DEBOUNCE_CYC,
    parameter integer RST_HOLD_CYC = `FPL_RST_HOLD_CYC
) (
    input  wire clock_in,
    input  wire rst_b_in,
    input  wire abort_button_in,
    input  wire reset_button_in,
    input  wire abort_ack_in,
    input  wire watchdog_expired_in,
    input  wire sw_sysreset_bit_in,
    input  wire sys_ctrl_role_in,
    input  wire board_fault_in,
    input  wire cpu_halted_in,
    input  wire local_cycle_active_in,
    input  wire net_bus_master_in,
    input  wire disk_bus_master_in,
    input  wire vme_master_cycle_in,
    input  wire vme_slave_access_in,
    output reg  abort_irq_out,
    output reg  board_reset_out,
    output reg  sysreset_out,
    output reg  fail_lamp_out,
    output reg  stat_lamp_out,
    output reg  run_lamp_out,
    output reg  system_controller_lamp_out,
    output reg  net_lamp_out,
    output reg  disk_lamp_out,
    output reg  vme_lamp_out
);
    wire       abort_rise;
    wire       reset_level;
    wire       reset_rise;
    wire       reset_request;
    wire       hold_busy;
    reg        wdog_reg;
    reg        pwr_up_reg;
    reg [`FPL_CNT_W-1:0] hold_reg;

    ////////////////////////////////////////////////////////////////////////////
    // true while a stretch counter still has cycles left; shared by both resets
    function count_busy;
        input [`FPL_CNT_W-1:0] count;
        begin
            count_busy = (count != {`FPL_CNT_W{1'b0}});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // button filters
    fpl_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(`FPL_CNT_W)) u_abort (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .button_in (abort_button_in),
        .level_out (),
        .rise_out  (abort_rise)
    );
    fpl_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(`FPL_CNT_W)) u_reset (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .button_in (reset_button_in),
        .level_out (reset_level),
        .rise_out  (reset_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // abort request is sticky until the processor acknowledges; set beats clear
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            abort_irq_out <= 1'b0;
        end else if (abort_rise) begin
            abort_irq_out <= 1'b1;
        end else if (abort_ack_in) begin
            abort_irq_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up marker: high through reset and one cycle after, so that
    // leaving reset alone still gives a full stretched board reset
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            pwr_up_reg <= 1'b1;
        end else begin
            pwr_up_reg <= 1'b0;
        end
    end

    // watchdog is on-chip logic, sampled once to close timing only
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            wdog_reg <= 1'b0;
        end else begin
            wdog_reg <= watchdog_expired_in;
        end
    end

    // any of the four sources; the button edge is kept so that a press that
    // ends early still loads a full stretch
    assign reset_request = pwr_up_reg || reset_rise || reset_level
                        || wdog_reg || sw_sysreset_bit_in;
    assign hold_busy     = count_busy(hold_reg);

    ////////////////////////////////////////////////////////////////////////////
    // reset stretcher: each source gives at least RST_HOLD_CYC of reset
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            hold_reg <= {`FPL_CNT_W{1'b0}};
        end else if (reset_request) begin
            hold_reg <= RST_HOLD_CYC[`FPL_CNT_W-1:0];
        end else if (hold_busy) begin
            hold_reg <= hold_reg - 1'b1;
        end
    end

    // on-board reset follows the held button at once, then the stretch
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            board_reset_out <= 1'b1;
        end else begin
            board_reset_out <= pwr_up_reg || reset_level || hold_busy;
        end
    end

    // backplane reset only while system controller: a board that is not
    // controller must never pull the shared line
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            sysreset_out <= 1'b0;
        end else begin
            sysreset_out <= sys_ctrl_role_in
                         && (pwr_up_reg || reset_level || hold_busy);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lamps: inputs are same-clock status, registered so lamps come from flops
    // and a one-cycle glitch of a status line is at most one cycle of light

    // board failure lamp
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            fail_lamp_out <= 1'b0;
        end else begin
            fail_lamp_out <= board_fault_in;
        end
    end

    // processor halted lamp
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            stat_lamp_out <= 1'b0;
        end else begin
            stat_lamp_out <= cpu_halted_in;
        end
    end

    // local bus cycle in progress lamp
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            run_lamp_out <= 1'b0;
        end else begin
            run_lamp_out <= local_cycle_active_in;
        end
    end

    // system controller role lamp
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            system_controller_lamp_out <= 1'b0;
        end else begin
            system_controller_lamp_out <= sys_ctrl_role_in;
        end
    end

    // network controller owns the local bus
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            net_lamp_out <= 1'b0;
        end else begin
            net_lamp_out <= net_bus_master_in;
        end
    end

    // disk controller owns the local bus
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            disk_lamp_out <= 1'b0;
        end else begin
            disk_lamp_out <= disk_bus_master_in;
        end
    end

    // backplane in use, as master or as slave
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            vme_lamp_out <= 1'b0;
        end else begin
            vme_lamp_out <= vme_master_cycle_in || vme_slave_access_in;
        end
    end
endmodule // fpl_front_panel
`default_nettype wire

/* bench/fpl_front_panel_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fpl_front_panel_sva (
    input wire logic clock_in, rst_b_in, reset_button_in, watchdog_expired_in,
    input wire logic sys_ctrl_role_in, board_fault_in, cpu_halted_in, local_cycle_active_in,
    input wire logic net_bus_master_in, disk_bus_master_in, vme_master_cycle_in,
    input wire logic vme_slave_access_in, board_reset_out, sysreset_out, fail_lamp_out,
    input wire logic stat_lamp_out, run_lamp_out, system_controller_lamp_out,
    input wire logic net_lamp_out, disk_lamp_out, vme_lamp_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // lamps trail their cause by one cycle; the cycle leaving reset is skipped
    property p_fail; $past(rst_b_in) |-> fail_lamp_out == $past(board_fault_in); endproperty
    a_fail: assert property (p_fail) else $error("fail lamp wrong");
    property p_stat; $past(rst_b_in) |-> stat_lamp_out == $past(cpu_halted_in); endproperty
    a_stat: assert property (p_stat) else $error("status lamp wrong");
    property p_run; $past(rst_b_in) |-> run_lamp_out == $past(local_cycle_active_in); endproperty
    a_run: assert property (p_run) else $error("run lamp wrong");
    property p_system_controller_lamp; $past(rst_b_in) |-> system_controller_lamp_out == $past(sys_ctrl_role_in);
    endproperty
    a_system_controller_lamp: assert property (p_system_controller_lamp) else $error("controller lamp wrong");
    property p_nd; $past(rst_b_in) |-> {net_lamp_out, disk_lamp_out}
        == $past({net_bus_master_in, disk_bus_master_in}); endproperty
    a_nd: assert property (p_nd) else $error("net or disk lamp wrong");
    property p_vme; $past(rst_b_in) |-> vme_lamp_out
        == ($past(vme_master_cycle_in) | $past(vme_slave_access_in)); endproperty
    a_vme: assert property (p_vme) else $error("backplane lamp wrong");
    // sources pass through a sync stage, so allow a few cycles
    property p_sys; watchdog_expired_in && sys_ctrl_role_in |-> ##[1:4] sysreset_out; endproperty
    a_sys: assert property (p_sys) else $error("backplane reset missing");
    property p_brst; reset_button_in [*8] |-> ##[0:8] board_reset_out; endproperty
    a_brst: assert property (p_brst) else $error("board reset missing");
endmodule // fpl_front_panel_sva
bind fpl_front_panel fpl_front_panel_sva u_sva (.*);
`default_nettype wire

/* bench/fpl_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpl_cpu_model #(parameter integer ACK_DLY = 3) (
    input  wire logic clock_in,
    input  wire logic irq_in,
    input  wire logic ack_en_in,
    output var logic  ack_out
);
    // console line of the far side: 8 data bits, 1 stop, no parity, 9600 baud
    localparam integer CONSOLE_BAUD = 9600;
    integer wait_cnt = 0;
    initial ack_out = 1'b0;
    // service the abort request late on purpose; never while service is off
    always @(negedge clock_in) begin
        ack_out <= (irq_in && ack_en_in && wait_cnt == ACK_DLY);
        if (!(irq_in && ack_en_in) || wait_cnt == ACK_DLY) wait_cnt <= 0;
        else wait_cnt <= wait_cnt + 1;
    end
endmodule // fpl_cpu_model
`default_nettype wire

/* bench/fpl_front_panel_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fpl_front_panel_tb_top;
    logic clock_in = 1'b0, rst_b_in = 1'b0, ab = 1'b0, rb = 1'b0, wd = 1'b0, sw = 1'b0;
    logic ack_en = 1'b0;
    logic [7:0] st = 8'h80;
    wire ack, irq, brst, srst;
    wire [6:0] lp;
    integer mismatches = 0, num_checks = 0, i;
    always #2 clock_in = ~clock_in;
    fpl_front_panel #(.DEBOUNCE_CYC(4), .RST_HOLD_CYC(3)) u_dut (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .abort_button_in(ab), .reset_button_in(rb), .abort_ack_in(ack),
        .watchdog_expired_in(wd), .sw_sysreset_bit_in(sw), .sys_ctrl_role_in(st[7]),
        .board_fault_in(st[6]), .cpu_halted_in(st[5]), .local_cycle_active_in(st[4]),
        .net_bus_master_in(st[3]), .disk_bus_master_in(st[2]), .vme_master_cycle_in(st[1]),
        .vme_slave_access_in(st[0]), .abort_irq_out(irq), .board_reset_out(brst),
        .sysreset_out(srst), .fail_lamp_out(lp[6]), .stat_lamp_out(lp[5]),
        .run_lamp_out(lp[4]), .system_controller_lamp_out(lp[3]), .net_lamp_out(lp[2]),
        .disk_lamp_out(lp[1]), .vme_lamp_out(lp[0]));
    fpl_cpu_model u_cpu (.clock_in(clock_in), .irq_in(irq), .ack_en_in(ack_en), .ack_out(ack));
    function logic [6:0] exp_lamps(input logic [7:0] s);
        return {s[6], s[5], s[4], s[7], s[3], s[2], s[1] | s[0]};
    endfunction
    task check(input logic [6:0] exp, input logic [6:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // bounded wait for irq (0), board reset (1) or backplane reset (2)
    task await(input int sel, input logic v);
        int n;
        for (n = 0; n < 40 && (sel == 0 ? irq : sel == 1 ? brst : srst) !== v; n++)
            @(negedge clock_in);
        if ((sel == 0 ? irq : sel == 1 ? brst : srst) !== v) begin mismatches++; wrap_up(); end
    endtask
    initial begin
        i = $urandom(32'hDF54E9BA);
        repeat (16) @(negedge clock_in);
        rst_b_in = 1'b1;
        await(2, 1'b1);
        await(1, 1'b0);
        check(7'h00, {6'h00, srst});
        // all-off and all-on first, then random status patterns
        for (i = 0; i < 60; i++) begin
            st = (i < 2) ? {8{i[0]}} : 8'($urandom);
            @(negedge clock_in);
            check(exp_lamps(st), lp);
        end
        st = 8'h80;
        ab = 1'b1;
        repeat (2) @(negedge clock_in);
        ab = 1'b0;
        repeat (12) @(negedge clock_in);
        check(7'h00, {6'h00, irq});
        ab = 1'b1;
        await(0, 1'b1);
        ack_en = 1'b1;
        await(0, 1'b0);
        ack_en = 1'b0;
        repeat (12) @(negedge clock_in);
        check(7'h00, {6'h00, irq});
        for (i = 0; i < 15; i++) begin
            ab = (i < 3) ? i[0] : 1'b0;
            @(negedge clock_in);
        end
        check(7'h00, {6'h00, irq});
        for (i = 0; i < 4; i++) begin
            st[7] = (i != 0);
            {sw, wd, rb} = (i < 2) ? 3'h1 : (i == 2) ? 3'h2 : 3'h4;
            repeat (12) @(negedge clock_in);
            check({5'h00, 1'b1, 1'(i > 0)}, {5'h00, brst, srst});
            {sw, wd, rb} = 3'h0;
            await(2, 1'b0);
            await(1, 1'b0);
        end
        wrap_up();
    end
endmodule // fpl_front_panel_tb_top
`default_nettype wire
